// ---- dv/tcmo_checker.sv ----
// Pin, compare state, counter and flag assertions for the timer compare output block
`timescale 1ns/1ps
module tcmo_checker
(
  // Clock, reset and controls
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] waveform_mode_select_i,
  input wire logic [2:0] clock_select_i,
  input wire tcmo_pkg::tcmo_unit_t [1:0] unit_i,
  input wire logic counter_wr_i,
  input wire logic [1:0] port_out_i,
  input wire logic [1:0] direction_bit_i,
  // Design outputs
  input wire logic [15:0] counter_value_o,
  input wire logic [1:0][15:0] compare_value_o,
  input wire logic overflow_flag_o,
  input wire logic [1:0] compare_match_flag_o,
  input wire logic [1:0] output_compare_state_o,
  input wire tcmo_pkg::tcmo_pin_t [1:0] pin_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  AST_OVR: assert property (unit_i[0].mode != 2'h0
    |=> pin_o[0].value == output_compare_state_o[0]) else $error("pin A not overridden");
  AST_PORT: assert property (unit_i[1].mode == 2'h0
    |=> pin_o[1].value == $past(port_out_i[1])) else $error("pin B lost port value");
  AST_DIR: assert property (!direction_bit_i[1] |=> !pin_o[1].oe)
    else $error("pin B driven as input");
  AST_KEEP: assert property (unit_i[0].mode == 2'h0
    |=> $stable(output_compare_state_o[0])) else $error("state A changed in mode off");
  AST_FSET: assert property (unit_i[1].force_s && unit_i[1].mode == 2'h3
    && waveform_mode_select_i == 4'h0 |=> output_compare_state_o[1])
    else $error("forced set missed");
  AST_FNF: assert property (unit_i[1].force_s && clock_select_i == 3'h0 && !counter_wr_i
    |=> $stable(counter_value_o) && !$rose(compare_match_flag_o[1]))
    else $error("force touched flag or counter");
  AST_TGL: assert property (waveform_mode_select_i == 4'h4 && clock_select_i == 3'h1
    && unit_i[0].mode == 2'h1 && !unit_i[0].force_s && !counter_wr_i && !$past(counter_wr_i)
    && counter_value_o == compare_value_o[0]
    |=> output_compare_state_o[0] != $past(output_compare_state_o[0])
    && counter_value_o == 16'h0 && compare_match_flag_o[0]) else $error("top toggle missed");
  AST_WRAP: assert property (waveform_mode_select_i == 4'h0 && clock_select_i == 3'h1
    && counter_value_o == 16'hffff && !counter_wr_i
    |=> counter_value_o == 16'h0 && overflow_flag_o) else $error("wrap or overflow wrong");
endmodule

// ---- dv/tcmo_pad_model.sv ----
// Port pad model with pull-up on undriven pins
`timescale 1ns/1ps
module tcmo_pad_model
(
  // Pin drive
  input wire tcmo_pkg::tcmo_pin_t [1:0] pin_i,
  // Pad levels
  output logic [1:0] pad_o
);
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pad_o[i] = pin_i[i].oe ? pin_i[i].value : 1'b1;
    end
  end
endmodule

// ---- dv/tcmo_top_tb.sv ----
// Self-checking bench for the timer compare output block
`timescale 1ns/1ps
module tcmo_top_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] wgm = 4'h0;
  logic [2:0] cs = 3'h0;
  tcmo_pkg::tcmo_unit_t [1:0] un = '0;
  logic cwr = 1'b0;
  logic [15:0] cwd = 16'h0;
  logic [15:0] icr = 16'h3;
  logic oclr = 1'b0;
  logic cclr = 1'b0;
  logic [1:0] po = 2'h0;
  logic [1:0] dir = 2'h0;
  logic [15:0] cnt;
  logic [1:0][15:0] cv;
  logic ovf;
  logic [1:0] mf;
  logic cf;
  logic [1:0] oc;
  tcmo_pkg::tcmo_pin_t [1:0] pin;
  logic [1:0] pad;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int dv [5] = '{1, 8, 64, 256, 1024};
  // Unit B rows: mode, port, direction, then expected state, value, enable
  logic [15:0] rows [8] = '{16'h0317, 16'h0231, 16'h0126, 16'h4111,
    16'h0033, 16'hf311, 16'hc317, 16'h5217};
  tcmo_top tcmo_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .waveform_mode_select_i(wgm),
    .clock_select_i(cs), .unit_i(un), .counter_wr_i(cwr), .counter_wdata_i(cwd),
    .capture_top_register_i(icr), .overflow_clr_i(oclr), .capture_clr_i(cclr),
    .port_out_i(po), .direction_bit_i(dir), .counter_value_o(cnt), .compare_value_o(cv),
    .overflow_flag_o(ovf), .compare_match_flag_o(mf), .capture_flag_o(cf),
    .output_compare_state_o(oc), .pin_o(pin));
  tcmo_pad_model tcmo_pad_model_inst (.pin_i(pin), .pad_o(pad));
  always #12.5 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cycles until state A changes
  task automatic wt(output int k);
    logic s;
    k = 0;
    s = oc[0];
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (oc[0] === s && k < 4000);
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    chk(oc, 16'h0);
    foreach (rows[r])
    begin
      wgm = rows[r][15:12];
      un[1].mode = rows[r][9:8];
      po[1] = rows[r][5];
      dir[1] = rows[r][4];
      un[1].force_s = 1'b1;
      @(negedge clk_i);
      un[1].force_s = 1'b0;
      @(negedge clk_i);
      chk(oc[1], rows[r][2]);
      chk(pin[1].value, rows[r][1]);
      chk(pin[1].oe, rows[r][0]);
      chk(pad[1], rows[r][0] ? rows[r][1] : 1'b1);
      chk(oc[0], 16'h0);
    end
    foreach (dv[k])
    begin
      cs = 3'h0;
      wgm = 4'h4;
      un[0].mode = 2'h1;
      un[0].wr = 1'b1;
      un[0].wdata = 16'h2;
      cwr = 1'b1;
      cwd = 16'h0;
      @(negedge clk_i);
      un[0].wr = 1'b0;
      cwr = 1'b0;
      cs = 3'(k + 1);
      wt(n);
      wt(n);
      chk(16'(n), 16'(3 * dv[k]));
      chk(mf[0], 1'b1);
    end
    cs = 3'h0;
    wgm = 4'h0;
    un[0].mode = 2'h0;
    un[0].wdata = 16'h5;
    un[0].wr = 1'b1;
    un[0].flag_clr = 1'b1;
    cwr = 1'b1;
    cwd = 16'h5;
    @(negedge clk_i);
    un[0].wr = 1'b0;
    un[0].flag_clr = 1'b0;
    cwr = 1'b0;
    cs = 3'h1;
    repeat (2) @(negedge clk_i);
    cs = 3'h0;
    chk(mf[0], 1'b0);
    chk(cnt, 16'h7);
    chk(cv[0], 16'h5);
    cwr = 1'b1;
    cwd = 16'hfffe;
    @(negedge clk_i);
    cwr = 1'b0;
    cs = 3'h1;
    repeat (2) @(negedge clk_i);
    cs = 3'h0;
    chk(cnt, 16'h0);
    chk(ovf, 1'b1);
    oclr = 1'b1;
    @(negedge clk_i);
    oclr = 1'b0;
    chk(ovf, 1'b0);
    wgm = 4'hc;
    cs = 3'h1;
    repeat (6) @(negedge clk_i);
    cs = 3'h0;
    chk(cf, 1'b1);
    cclr = 1'b1;
    @(negedge clk_i);
    cclr = 1'b0;
    chk(cf, 1'b0);
    // Buffered write in fast PWM lands only at top
    wgm = 4'hf;
    un[0].wdata = 16'h9;
    un[0].wr = 1'b1;
    @(negedge clk_i);
    un[0].wr = 1'b0;
    chk(cv[0], 16'h5);
    cs = 3'h1;
    repeat (4) @(negedge clk_i);
    cs = 3'h0;
    chk(cv[0], 16'h9);
    // Both states set before reset so the reset check can fail
    wgm = 4'h0;
    un[0].mode = 2'h3;
    un[1].mode = 2'h3;
    un[0].force_s = 1'b1;
    un[1].force_s = 1'b1;
    @(negedge clk_i);
    un[0].force_s = 1'b0;
    un[1].force_s = 1'b0;
    chk(oc, 16'h3);
    resetn_i = 1'b0;
    @(negedge clk_i);
    chk(oc, 16'h0);
    complete_run();
  end
endmodule
bind tcmo_top tcmo_checker tcmo_checker_inst (.clk_i(clk_i), .resetn_i(resetn_i),
  .waveform_mode_select_i(waveform_mode_select_i), .clock_select_i(clock_select_i),
  .unit_i(unit_i), .counter_wr_i(counter_wr_i), .port_out_i(port_out_i),
  .direction_bit_i(direction_bit_i), .counter_value_o(counter_value_o),
  .compare_value_o(compare_value_o), .overflow_flag_o(overflow_flag_o),
  .compare_match_flag_o(compare_match_flag_o),
  .output_compare_state_o(output_compare_state_o), .pin_o(pin_o));

// ---- verilog/tcmo_pkg.sv ----
// Constants, types and state layout of the timer compare output unit
package tcmo_pkg;

  localparam int CNT_W = 16;
  localparam int PRESC_W = 10;
  localparam int UNITS = 2;
  localparam int UNIT_A = 0;

  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;

  // Waveform modes handled here
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_OCR = 4'h4;
  localparam logic [3:0] WGM_CTC_ICR = 4'hc;
  localparam logic [3:0] WGM_FPWM_OCR = 4'hf;

  // Compare output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Prescaler selects and divider masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

  localparam logic OC_RST = 1'b0;

  // Per-unit control from the CPU side
  typedef struct packed {
    logic [1:0] mode;
    logic force_s;
    logic wr;
    logic [15:0] wdata;
    logic flag_clr;
  } tcmo_unit_t;

  typedef struct packed {
    logic value;
    logic oe;
  } tcmo_pin_t;

  typedef struct packed {
    logic [9:0] presc;
    logic [15:0] cnt;
    logic [1:0][15:0] ocr;
    logic [1:0][15:0] ocr_buf;
    logic [1:0] oc;
    logic [1:0] ocf;
    logic tov;
    logic icf;
    logic block;
    tcmo_pin_t [1:0] pin;
  } tcmo_state_t;

  localparam tcmo_state_t STATE_RST = '0;

endpackage

// ---- verilog/tcmo_top.sv ----
// Timer counter with normal, clear-on-match and compare output units
`timescale 1ns/1ps
module tcmo_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Timer configuration
  input wire logic [3:0] waveform_mode_select_i,
  input wire logic [2:0] clock_select_i,
  // Compare units A and B
  input wire tcmo_pkg::tcmo_unit_t [1:0] unit_i,
  // Counter access
  input wire logic counter_wr_i,
  input wire logic [15:0] counter_wdata_i,
  // Capture register used as top
  input wire logic [15:0] capture_top_register_i,
  // Flag clears
  input wire logic overflow_clr_i,
  input wire logic capture_clr_i,
  // Port pin logic
  input wire logic [1:0] port_out_i,
  input wire logic [1:0] direction_bit_i,
  // Status
  output logic [15:0] counter_value_o,
  output logic [1:0][15:0] compare_value_o,
  output logic overflow_flag_o,
  output logic [1:0] compare_match_flag_o,
  output logic capture_flag_o,
  output logic [1:0] output_compare_state_o,
  // Pins
  output tcmo_pkg::tcmo_pin_t [1:0] pin_o
);

  tcmo_pkg::tcmo_state_t s_r;
  tcmo_pkg::tcmo_state_t s_nxt;

  // PWM decode, shared by buffering and force gating
  function automatic logic is_pwm(input logic [3:0] wgm);
    logic r;
    r = 1'b1;
    if (wgm == tcmo_pkg::WGM_NORMAL)
    begin
      r = 1'b0;
    end
    if (wgm == tcmo_pkg::WGM_CTC_OCR || wgm == tcmo_pkg::WGM_CTC_ICR)
    begin
      r = 1'b0;
    end
    return r;
  endfunction

  // Modes whose counter clears at top
  function automatic logic clears_at_top(input logic [3:0] wgm);
    logic r;
    r = 1'b0;
    case (wgm)
      tcmo_pkg::WGM_CTC_OCR: r = 1'b1;
      tcmo_pkg::WGM_CTC_ICR: r = 1'b1;
      tcmo_pkg::WGM_FPWM_OCR: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Timer tick from the free prescaler
  function automatic logic presc_tick(input logic [2:0] cs, input logic [9:0] p);
    logic r;
    r = 1'b0;
    case (cs)
      tcmo_pkg::CS_DIV1: r = 1'b1;
      tcmo_pkg::CS_DIV8: r = (p & tcmo_pkg::MASK_DIV8) == tcmo_pkg::MASK_DIV8;
      tcmo_pkg::CS_DIV64: r = (p & tcmo_pkg::MASK_DIV64) == tcmo_pkg::MASK_DIV64;
      tcmo_pkg::CS_DIV256: r = (p & tcmo_pkg::MASK_DIV256) == tcmo_pkg::MASK_DIV256;
      tcmo_pkg::CS_DIV1024: r = (p & tcmo_pkg::MASK_DIV1024) == tcmo_pkg::MASK_DIV1024;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // State after a match or a forced compare
  function automatic logic match_action(
    input logic [1:0] com,
    input logic oc,
    input logic toggle_ok
  );
    logic r;
    r = oc;
    case (com)
      tcmo_pkg::COM_TOGGLE:
      begin
        if (toggle_ok)
        begin
          r = ~oc;
        end
      end
      tcmo_pkg::COM_CLEAR: r = 1'b0;
      tcmo_pkg::COM_SET: r = 1'b1;
      default: r = oc;
    endcase
    return r;
  endfunction

  // State at the top-to-bottom step in fast PWM
  function automatic logic bottom_action(input logic [1:0] com, input logic oc);
    logic r;
    r = oc;
    case (com)
      tcmo_pkg::COM_CLEAR: r = 1'b1;
      tcmo_pkg::COM_SET: r = 1'b0;
      default: r = oc;
    endcase
    return r;
  endfunction

  logic tick;
  logic pwm;
  logic [15:0] top;
  logic at_top;
  logic at_max;
  logic [1:0] ocf_set;
  logic tov_set;
  logic icf_set;

  always_comb
  begin
    s_nxt = s_r;
    pwm = is_pwm(waveform_mode_select_i);
    tick = presc_tick(clock_select_i, s_r.presc);
    // Top from capture register or compare value A
    if (waveform_mode_select_i == tcmo_pkg::WGM_CTC_ICR)
    begin
      top = capture_top_register_i;
    end
    else
    begin
      top = s_r.ocr[tcmo_pkg::UNIT_A];
    end
    at_top = clears_at_top(waveform_mode_select_i) && (s_r.cnt == top);
    at_max = s_r.cnt == tcmo_pkg::CNT_MAX;
    ocf_set = 2'b00;
    tov_set = 1'b0;
    icf_set = 1'b0;

    if (clock_select_i == tcmo_pkg::CS_STOP)
    begin
      s_nxt.presc = '0;
    end
    else
    begin
      s_nxt.presc = s_r.presc + 10'h001;
    end

    // Counting, matches and flags only on ticks
    if (tick)
    begin
      s_nxt.block = 1'b0;
      // Counting chosen by waveform mode alone
      if (at_top)
      begin
        s_nxt.cnt = tcmo_pkg::CNT_BOTTOM;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
      if (waveform_mode_select_i == tcmo_pkg::WGM_FPWM_OCR)
      begin
        tov_set = at_top;
        if (at_top)
        begin
          s_nxt.ocr = s_r.ocr_buf;
        end
      end
      else
      begin
        tov_set = at_max && !at_top;
      end
      icf_set = at_top && (waveform_mode_select_i == tcmo_pkg::WGM_CTC_ICR);
      for (int u = 0; u < tcmo_pkg::UNITS; u++)
      begin
        // A counter write blanks the next compare
        if (s_r.cnt == s_r.ocr[u] && !s_r.block)
        begin
          ocf_set[u] = 1'b1;
          // Mode read at the match itself
          s_nxt.oc[u] = match_action(unit_i[u].mode, s_r.oc[u],
            !pwm || (u == tcmo_pkg::UNIT_A));
        end
        if (pwm && at_top)
        begin
          s_nxt.oc[u] = bottom_action(unit_i[u].mode, s_nxt.oc[u]);
        end
      end
    end

    // CPU counter write wins over counting
    if (counter_wr_i)
    begin
      s_nxt.cnt = counter_wdata_i;
      s_nxt.block = 1'b1;
    end

    for (int u = 0; u < tcmo_pkg::UNITS; u++)
    begin
      if (unit_i[u].wr)
      begin
        s_nxt.ocr_buf[u] = unit_i[u].wdata;
        // Unbuffered outside PWM
        if (!pwm)
        begin
          s_nxt.ocr[u] = unit_i[u].wdata;
        end
      end
      // Forced compare: state only, no flag or counter change
      if (unit_i[u].force_s && !pwm)
      begin
        s_nxt.oc[u] = match_action(unit_i[u].mode, s_r.oc[u], 1'b1);
      end
      // Set wins over clear
      s_nxt.ocf[u] = (s_r.ocf[u] && !unit_i[u].flag_clr) || ocf_set[u];
      // Override picked by compare output mode only
      if (unit_i[u].mode != tcmo_pkg::COM_OFF)
      begin
        s_nxt.pin[u].value = s_nxt.oc[u];
      end
      else
      begin
        s_nxt.pin[u].value = port_out_i[u];
      end
      s_nxt.pin[u].oe = direction_bit_i[u];
    end

    s_nxt.tov = (s_r.tov && !overflow_clr_i) || tov_set;
    // Capture flag only from top; compare modes take no part
    s_nxt.icf = (s_r.icf && !capture_clr_i) || icf_set;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r <= tcmo_pkg::STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign counter_value_o = s_r.cnt;
  assign compare_value_o = s_r.ocr;
  assign overflow_flag_o = s_r.tov;
  assign compare_match_flag_o = s_r.ocf;
  assign capture_flag_o = s_r.icf;
  assign output_compare_state_o = s_r.oc;
  assign pin_o = s_r.pin;

endmodule
